// ==== serial_frame_pkg.sv ====
package serial_frame_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int unsigned DATA_W = 16;
	localparam int unsigned DIV_W = 8;
	localparam int unsigned EDGE_W = 6;
	localparam int unsigned SIZE_W = 4;

	// ****************************************************************
	// edge indices of a frame (edge 0 is the first clock transition)
	// ****************************************************************
	localparam logic [EDGE_W-1:0] SPI_LAST_EDGE_BASE = 6'h01;
	localparam logic [EDGE_W-1:0] CMD_LAST_CTRL_SHIFT = 6'h0d; // falling edge after 7th bit
	localparam logic [EDGE_W-1:0] CMD_FIRST_RX_EDGE = 6'h12; // rising edge after wait state
	localparam logic [EDGE_W-1:0] CMD_LAST_EDGE_BASE = 6'h13;
	localparam logic [EDGE_W-1:0] EDGE_ZERO = 6'h00;
	localparam logic [SIZE_W-1:0] WORD_MSB_IDX = 4'hf;
	localparam logic [1:0] TAIL_HALVES_LONG = 2'h2;
	localparam logic [1:0] TAIL_HALVES_SHORT = 2'h1;

	typedef enum logic {
		FMT_SPI = 1'b0,
		FMT_CMDRESP = 1'b1
	} frame_fmt_e;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_LEAD = 6'b000010,
		ST_RUN = 6'b000100,
		ST_TAIL = 6'b001000,
		ST_GAP = 6'b010000,
		ST_SLAVE = 6'b100000
	} engine_state_e;

	// index of the final clock edge of one word
	function automatic logic [EDGE_W-1:0] last_edge(input logic is_cmd,
			input logic [SIZE_W-1:0] size_m1);
		logic [EDGE_W-1:0] twice;
		twice = {1'b0, size_m1, 1'b0};
		last_edge = is_cmd ? twice + CMD_LAST_EDGE_BASE : twice + SPI_LAST_EDGE_BASE;
	endfunction : last_edge

	// word placed msb-first at the top of the shifter
	function automatic logic [DATA_W-1:0] align_tx(input logic is_cmd,
			input logic [SIZE_W-1:0] size_m1, input logic [DATA_W-1:0] word);
		align_tx = is_cmd ? {word[7:0], 8'h00} : word << (WORD_MSB_IDX - size_m1);
	endfunction : align_tx

endpackage : serial_frame_pkg

// ==== slave_pins_if.sv ====
`timescale 1ns/100ps

// synchronised link pins and clock edges seen by the engine
interface slave_pins_if;
	logic sclk;
	logic rise;
	logic fall;
	logic fss;
	logic rx;
	modport src (output sclk, rise, fall, fss, rx);
	modport dst (input sclk, rise, fall, fss, rx);
endinterface : slave_pins_if

// ==== pin_sync.sv ====
`timescale 1ns/100ps

module pin_sync (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic sclk_i,
	input wire logic fss_i,
	input wire logic rx_i,
	slave_pins_if.src pins
);

	logic [2:0] meta;
	logic [2:0] sync;
	logic sclk_d;

	// two stages; select resets high so no false frame start
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta <= 3'h2;
			sync <= 3'h2;
			sclk_d <= 1'b0;
		end else begin
			meta <= {sclk_i, fss_i, rx_i};
			sync <= meta;
			sclk_d <= sync[2];
		end
	end

	// edges come from the settled stage only
	assign pins.sclk = sync[2];
	assign pins.rise = sync[2] & ~sclk_d;
	assign pins.fall = ~sync[2] & sclk_d;
	assign pins.fss = sync[1];
	assign pins.rx = sync[0];

endmodule : pin_sync

// ==== half_timer.sv ====
`timescale 1ns/100ps

module half_timer
	import serial_frame_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic run_i,
	input wire logic [DIV_W-1:0] div_i,
	output logic tick_o
);

	logic [DIV_W-1:0] cnt;
	wire logic [DIV_W-1:0] top = (div_i == '0) ? '0 : div_i - 8'h01;

	// one pulse per half serial period; restarts whenever the engine rests
	assign tick_o = run_i && (cnt == top);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= '0;
		end else if (!run_i || tick_o) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

endmodule : half_timer

// ==== sync_serial_frame_engine.sv ====
`timescale 1ns/100ps

module sync_serial_frame_engine
	import serial_frame_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic ENABLE_I,
	input wire logic MASTER_I,
	input wire logic FORMAT_I,
	input wire logic CLOCK_POLARITY_BIT_I,
	input wire logic CLOCK_PHASE_BIT_I,
	input wire logic [SIZE_W-1:0] DATA_SIZE_I,
	input wire logic [DIV_W-1:0] CLOCK_DIV_I,
	input wire logic TX_VALID_I,
	input wire logic [DATA_W-1:0] TX_DATA_I,
	output logic TX_READY_O,
	output logic RX_VALID_O,
	output logic [DATA_W-1:0] RX_DATA_O,
	output logic BUSY_O,
	input wire logic SERIAL_CLOCK_LINE_I,
	output logic SERIAL_CLOCK_LINE_O,
	output logic SERIAL_CLOCK_LINE_OE_O,
	input wire logic FRAME_SELECT_LINE_I,
	output logic FRAME_SELECT_LINE_O,
	output logic FRAME_SELECT_LINE_OE_O,
	output logic SERIAL_OUT_LINE_O,
	output logic SERIAL_OUT_LINE_OE_O,
	input wire logic SERIAL_IN_LINE_I
);

	// ****************************************************************
	// pin synchronisers and half-period timer
	// ****************************************************************
	slave_pins_if pins ();

	pin_sync u_sync (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.sclk_i(SERIAL_CLOCK_LINE_I),
		.fss_i(FRAME_SELECT_LINE_I),
		.rx_i(SERIAL_IN_LINE_I),
		.pins(pins)
	);

	engine_state_e state;
	engine_state_e next_state;
	logic tick;
	logic [EDGE_W-1:0] edge_cnt;
	logic [1:0] halves;
	logic [DATA_W-1:0] tx_shift;
	logic [DATA_W-1:0] rx_shift;
	logic first_q;
	logic sclk_q;
	logic sclk_oe_q;
	logic fss_q;
	logic fss_oe_q;
	logic out_q;
	logic out_oe_q;
	logic rx_valid_q;
	logic [DATA_W-1:0] rx_data_q;
	logic load;
	logic push;
	logic edge_go;

	// timer runs only while a master frame or the gap after it is under way
	wire logic timer_run = (state == ST_LEAD) || (state == ST_RUN) ||
		(state == ST_TAIL) || (state == ST_GAP);

	half_timer u_timer (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.run_i(timer_run),
		.div_i(CLOCK_DIV_I),
		.tick_o(tick)
	);

	// ****************************************************************
	// format decode
	// ****************************************************************
	// command format always uses a low-idle clock and latch-on-rise
	wire logic is_cmd = (FORMAT_I == FMT_CMDRESP);
	wire logic cpol = CLOCK_POLARITY_BIT_I & ~is_cmd;
	wire logic cpha = CLOCK_PHASE_BIT_I & ~is_cmd;
	wire logic [EDGE_W-1:0] last_e = last_edge(is_cmd, DATA_SIZE_I);
	wire logic at_last = (edge_cnt == last_e);
	wire logic m_even = ~edge_cnt[0];
	wire logic m_edge = (state == ST_RUN) && tick;
	wire logic chain = TX_VALID_I && ENABLE_I && (is_cmd || cpha);
	wire logic gap_ok = TX_VALID_I && ENABLE_I && !is_cmd && !cpha;
	wire logic [1:0] tail_need = (!is_cmd && cpha) ? TAIL_HALVES_LONG : TAIL_HALVES_SHORT;
	wire logic tail_done = (halves == tail_need - TAIL_HALVES_SHORT);

	// ****************************************************************
	// master edge actions
	// ****************************************************************
	// phase 0 captures on even edges, phase 1 on odd ones
	wire logic m_cap_spi = m_even ^ cpha;
	// control bits go out, nothing is taken in before the response
	wire logic m_cap_cmd = m_even && (edge_cnt >= CMD_FIRST_RX_EDGE);
	wire logic m_cap = m_edge && (is_cmd ? m_cap_cmd : m_cap_spi);
	wire logic m_sh_cmd = !m_even && (edge_cnt <= CMD_LAST_CTRL_SHIFT);
	wire logic m_sh_spi = cpha ? (m_even && edge_cnt != EDGE_ZERO) : (!m_even && !at_last);
	wire logic m_shift = m_edge && (is_cmd ? m_sh_cmd : m_sh_spi);
	// phase 1 shows the msb together with the first edge
	wire logic m_present0 = m_edge && !is_cmd && cpha && (edge_cnt == EDGE_ZERO);
	// phase 0 shows the msb half a period after select falls
	wire logic lead_exit = (state == ST_LEAD) && tick;

	// ****************************************************************
	// slave edge actions
	// ****************************************************************
	// timing comes entirely from the synchronised external clock and select
	wire logic s_act = (state == ST_SLAVE) && !pins.fss;
	wire logic s_lead = cpol ? pins.fall : pins.rise;
	wire logic s_trail = cpol ? pins.rise : pins.fall;
	wire logic s_cap = s_act && (cpha ? s_trail : s_lead);
	wire logic s_shift = s_act && (cpha ? (s_lead && !first_q) : s_trail);
	wire logic s_last = (edge_cnt == {2'h0, DATA_SIZE_I});

	wire logic capture = m_cap || s_cap;
	wire logic shift = m_shift || s_shift;
	// only command master and slave put the msb out at load time
	wire logic present = shift || lead_exit || m_present0 ||
		(load && (is_cmd || !MASTER_I));
	wire logic [DATA_W-1:0] load_word = TX_VALID_I ? TX_DATA_I : '0;
	wire logic [DATA_W-1:0] next_tx = load ? align_tx(is_cmd, DATA_SIZE_I, load_word) :
		shift ? {tx_shift[DATA_W-2:0], 1'b0} : tx_shift;
	wire logic [DATA_W-1:0] next_rx = capture ? {rx_shift[DATA_W-2:0], pins.rx} : rx_shift;
	wire logic next_frame = (next_state == ST_LEAD) || (next_state == ST_RUN) ||
		(next_state == ST_TAIL);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	// an empty source in slave mode sends zeros; a slave must keep it fed
	always_comb begin
		next_state = state;
		load = 1'b0;
		push = 1'b0;
		edge_go = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (ENABLE_I && MASTER_I && TX_VALID_I) begin
					load = 1'b1;
					next_state = (is_cmd || cpha) ? ST_RUN : ST_LEAD;
				end else if (ENABLE_I && !MASTER_I && !pins.fss) begin
					load = 1'b1;
					next_state = ST_SLAVE;
				end
			end
			ST_LEAD: begin
				if (tick) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (tick) begin
					edge_go = 1'b1;
					if (at_last && chain) begin
						load = 1'b1;
						push = 1'b1;
					end else if (at_last) begin
						next_state = ST_TAIL;
						push = !is_cmd;
					end
				end
			end
			ST_TAIL: begin
				if (tick && tail_done) begin
					push = is_cmd;
					next_state = gap_ok ? ST_GAP : ST_IDLE;
				end
			end
			ST_GAP: begin
				if (tick && TX_VALID_I) begin
					load = 1'b1;
					next_state = ST_LEAD;
				end else if (tick) begin
					next_state = ST_IDLE;
				end
			end
			ST_SLAVE: begin
				if (pins.fss || !ENABLE_I) begin
					next_state = ST_IDLE;
				end else if (s_cap && s_last) begin
					push = 1'b1;
					load = cpha;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// edge index in master, bit count in slave
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			edge_cnt <= '0;
		end else if (load) begin
			edge_cnt <= '0;
		end else if (edge_go || s_cap) begin
			edge_cnt <= edge_cnt + 6'h01;
		end
	end

	// half periods spent after the final edge
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			halves <= '0;
		end else if (state != ST_TAIL) begin
			halves <= '0;
		end else if (tick) begin
			halves <= halves + 2'h1;
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			first_q <= 1'b0;
		end else if (load) begin
			first_q <= 1'b1;
		end else if (s_lead) begin
			first_q <= 1'b0;
		end
	end

	// ****************************************************************
	// shifters and received word
	// ****************************************************************
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			tx_shift <= '0;
			rx_shift <= '0;
		end else begin
			tx_shift <= next_tx;
			rx_shift <= load ? '0 : next_rx;
		end
	end

	// word is complete once the last capture has landed
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rx_data_q <= '0;
			rx_valid_q <= 1'b0;
		end else begin
			rx_valid_q <= push;
			if (push) begin
				rx_data_q <= next_rx;
			end
		end
	end

	// ****************************************************************
	// line drivers
	// ****************************************************************
	// clock only moves on sequencer edges; idle level follows polarity
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sclk_q <= 1'b0;
		end else if (edge_go) begin
			sclk_q <= ~sclk_q;
		end else if (state == ST_IDLE || state == ST_SLAVE) begin
			sclk_q <= cpol;
		end
	end

	// select low for the whole frame, high between phase 0 words
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			fss_q <= 1'b1;
			sclk_oe_q <= 1'b0;
			fss_oe_q <= 1'b0;
			out_oe_q <= 1'b0;
		end else begin
			fss_q <= !next_frame;
			sclk_oe_q <= MASTER_I;
			fss_oe_q <= MASTER_I;
			out_oe_q <= MASTER_I ? (next_state != ST_IDLE) :
				((next_state == ST_SLAVE) && !pins.fss);
		end
	end

	// data line rests low once the engine returns to idle
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			out_q <= 1'b0;
		end else if (next_state == ST_IDLE) begin
			out_q <= 1'b0;
		end else if (present) begin
			out_q <= next_tx[DATA_W-1];
		end
	end

	assign TX_READY_O = load && TX_VALID_I;
	assign RX_VALID_O = rx_valid_q;
	assign RX_DATA_O = rx_data_q;
	assign BUSY_O = (state != ST_IDLE);
	assign SERIAL_CLOCK_LINE_O = sclk_q;
	assign SERIAL_CLOCK_LINE_OE_O = sclk_oe_q;
	assign FRAME_SELECT_LINE_O = fss_q;
	assign FRAME_SELECT_LINE_OE_O = fss_oe_q;
	assign SERIAL_OUT_LINE_O = out_q;
	assign SERIAL_OUT_LINE_OE_O = out_oe_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	property p_idle_lines;
		(state == ST_IDLE && $past(state) == ST_IDLE && $past(cpol) == cpol)
			|-> (sclk_q == cpol) && fss_q && !out_q;
	endproperty
	a_idle_lines: assert property (p_idle_lines) else $error("idle lines wrong");

	property p_pad_oe;
		// the enable register only follows the mode from the first edge after reset
		MASTER_I && $past(MASTER_I) && $past(RSTN_I) |-> sclk_oe_q ##1 !MASTER_I |=> !sclk_oe_q;
	endproperty
	a_pad_oe: assert property (p_pad_oe) else $error("clock pad enable wrong");

	property p_start;
		(state == ST_IDLE && MASTER_I && load) |=> !fss_q && out_oe_q;
	endproperty
	a_start: assert property (p_start) else $error("frame start wrong");

	property p_sclk_quiet;
		($changed(sclk_q) && $past(state) != ST_IDLE && $past(state) != ST_SLAVE)
			|-> $past(state) == ST_RUN && $past(tick);
	endproperty
	a_sclk_quiet: assert property (p_sclk_quiet) else $error("clock moved outside frame");

	property p_fss_rise;
		$rose(fss_q) && MASTER_I |-> $past(state) == ST_TAIL || $past(state) == ST_RUN;
	endproperty
	a_fss_rise: assert property (p_fss_rise) else $error("select rose early");

	property p_gap_phase0;
		(state == ST_TAIL && next_state == ST_GAP) |-> !cpha && !is_cmd ##1 fss_q;
	endproperty
	a_gap_phase0: assert property (p_gap_phase0) else $error("gap in wrong mode");

	property p_ctrl_no_rx;
		// a wandering receive line must leave no trace before the response
		(m_edge && is_cmd && edge_cnt < CMD_FIRST_RX_EDGE) |=> rx_shift == '0;
	endproperty
	a_ctrl_no_rx: assert property (p_ctrl_no_rx) else $error("capture during control");

	property p_frame_len;
		(state == ST_RUN) |-> edge_cnt <= last_e;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("word overran its length");

	property p_cmd_msb;
		(load && is_cmd && MASTER_I && TX_VALID_I) |=> out_q == $past(TX_DATA_I[7]);
	endproperty
	a_cmd_msb: assert property (p_cmd_msb) else $error("control msb not shown");

	property p_chain_hold;
		(m_edge && at_last && chain) |=> !fss_q && state == ST_RUN;
	endproperty
	a_chain_hold: assert property (p_chain_hold) else $error("select lifted in chain");

	c_gap: cover property (state == ST_GAP ##[1:600] state == ST_RUN);
	c_cmd_chain: cover property (m_edge && at_last && chain && is_cmd);
	c_slave_word: cover property (state == ST_SLAVE && push);

endmodule : sync_serial_frame_engine

// ==== serial_slave_model.sv ====
`timescale 1ns/100ps

// ****
// off-chip slave: full duplex, or command byte then response
// ****
module serial_slave_model (
	input wire logic sclk_i,
	input wire logic fss_i,
	input wire logic mosi_i,
	input wire logic cpol_i,
	input wire logic cpha_i,
	input wire logic cmd_i,
	input wire logic [3:0] size_i,
	input wire logic [15:0] reply_i,
	output logic miso_o,
	output logic [15:0] cap_o,
	output int cap_n_o
);
	int lead = 0;
	int trail = 0;
	int k;
	logic [15:0] sh = 16'h0000;
	logic junk = 1'b0;
	wire logic [15:0] rep = reply_i + 16'(cap_n_o);
	wire logic pol = cmd_i ? 1'b0 : cpol_i;
	initial cap_n_o = 0;
	// a released line wanders so a stale bit never looks valid
	always #3 junk = ~junk;
	// select fall restarts the bit count
	always @(negedge fss_i) begin
		lead = 0;
		trail = 0;
	end
	// capture edges per phase; control bits latched on rising
	always @(sclk_i) if (!fss_i) begin
		if (sclk_i !== pol) begin
			lead++;
			if (cmd_i ? lead <= 8 : !cpha_i) sh = {sh[14:0], mosi_i};
		end else begin
			trail++;
			if (!cmd_i && cpha_i) sh = {sh[14:0], mosi_i};
			if (trail == (cmd_i ? 10 : 1) + int'(size_i)) begin
				cap_o = sh;
				sh = 16'h0000;
				lead = 0;
				trail = 0;
				cap_n_o++;
			end
		end
	end
	// response after a one-clock wait, driven on falling, msb first
	always @* begin
		k = cmd_i ? ((trail >= 9) ? trail - 9 : -1) : (cpha_i ? ((lead > 0) ? lead - 1 : 0) : trail);
		miso_o = (fss_i || k < 0) ? junk : rep[int'(size_i) - k];
	end
endmodule : serial_slave_model

// ==== tb.sv ====
`timescale 1ns/100ps

module tb
	import serial_frame_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic enable = 1'b1;
	logic master = 1'b1;
	logic fmt = 1'b0;
	logic cpol = 1'b0;
	logic cpha = 1'b0;
	logic [SIZE_W-1:0] size = 4'h7;
	logic [DIV_W-1:0] div = 8'h04;
	logic tx_valid = 1'b0;
	logic [DATA_W-1:0] tx_data = 16'h0000;
	logic m_sclk = 1'b0;
	logic m_fss = 1'b1;
	logic m_mosi = 1'b0;
	logic [15:0] reply = 16'h0000;
	wire logic tx_ready, rx_valid, busy, sclk_o, sclk_oe, fss_o, fss_oe, sout, sout_oe, miso;
	wire logic [DATA_W-1:0] rx_data;
	wire logic [15:0] cap;
	int cap_n;
	int fails = 0;
	int checks_done = 0;
	int sent = 0;
	int n_edges, idle_edges, n_rise, n_fall;
	realtime t_fall, t_first, t_last, t_rise;
	logic watch = 1'b0;
	logic [31:0] seed = 32'h26e9;
	logic [15:0] capq[$];
	logic [15:0] rxq[$];
	// clock and select resolve from whoever enables them; the data input follows the mode
	wire logic sclk_w = sclk_oe ? sclk_o : m_sclk;
	wire logic fss_w = fss_oe ? fss_o : m_fss;
	wire logic sin = master ? miso : m_mosi;

	always #2 clk = ~clk;

	sync_serial_frame_engine sync_serial_frame_engine_i (.CLK_I(clk), .RSTN_I(rstn),
		.ENABLE_I(enable), .MASTER_I(master), .FORMAT_I(fmt), .CLOCK_POLARITY_BIT_I(cpol),
		.CLOCK_PHASE_BIT_I(cpha), .DATA_SIZE_I(size), .CLOCK_DIV_I(div),
		.TX_VALID_I(tx_valid), .TX_DATA_I(tx_data), .TX_READY_O(tx_ready),
		.RX_VALID_O(rx_valid), .RX_DATA_O(rx_data), .BUSY_O(busy),
		.SERIAL_CLOCK_LINE_I(sclk_w), .SERIAL_CLOCK_LINE_O(sclk_o),
		.SERIAL_CLOCK_LINE_OE_O(sclk_oe), .FRAME_SELECT_LINE_I(fss_w),
		.FRAME_SELECT_LINE_O(fss_o), .FRAME_SELECT_LINE_OE_O(fss_oe),
		.SERIAL_OUT_LINE_O(sout), .SERIAL_OUT_LINE_OE_O(sout_oe), .SERIAL_IN_LINE_I(sin));

	serial_slave_model serial_slave_model_i (.sclk_i(sclk_w), .fss_i(fss_w), .mosi_i(sout),
		.cpol_i(cpol), .cpha_i(cpha), .cmd_i(fmt), .size_i(size), .reply_i(reply),
		.miso_o(miso), .cap_o(cap), .cap_n_o(cap_n));

	// ****
	// monitors
	// ****
	always @(posedge clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);
	always @(cap_n) capq.push_back(cap);
	always @(sclk_w) if (watch) begin
		if (fss_w) idle_edges++;
		else begin
			n_edges++;
			if (n_edges == 1) t_first = $realtime;
			t_last = $realtime;
		end
	end
	always @(negedge fss_w) if (watch) begin
		if (n_fall == 0) t_fall = $realtime;
		n_fall++;
	end
	always @(posedge fss_w) if (watch) begin
		n_rise++;
		t_rise = $realtime;
	end

	// ****
	// helpers
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [15:0] mask(input logic [3:0] sz);
		return 16'hffff >> (4'hf - sz);
	endfunction : mask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize

	// hold the word until the edge that takes it; called 1 ns after an edge
	task automatic push(input logic [15:0] w);
		int i;
		i = 0;
		tx_valid = 1'b1;
		tx_data = w;
		#2;
		while (tx_ready !== 1'b1 && i < 5000) begin
			@(posedge clk);
			#3;
			i++;
		end
		check("take", i < 5000, 1'b1);
		@(posedge clk);
		#1;
	endtask : push

	// one master burst in a given mode; mode 4 is command-response
	task automatic run_case(input int mode, input int nw);
		int i;
		int bits;
		int d;
		logic [15:0] w[2];
		cpol = 1'(mode & 1);
		cpha = 1'((mode >> 1) & 1);
		fmt = (mode == 4);
		seed = lfsr(seed);
		size = (mode == 0) ? 4'h3 : (mode == 1) ? 4'hf : 4'(3 + seed % 13);
		div = 8'(4 + seed[17:16]);
		reply = seed[31:16];
		bits = int'(size) + 1;
		d = int'(div);
		repeat (4) @(posedge clk);
		#1;
		check("idle clock", sclk_o, cpol);
		check("idle select", fss_o, 1'b1);
		check("idle data", sout, 1'b0);
		check("clock pad", sclk_oe, 1'b1);
		check("select pad", fss_oe, 1'b1);
		check("idle out enable", sout_oe, 1'b0);
		{n_edges, idle_edges, n_rise, n_fall} = '0;
		capq.delete();
		rxq.delete();
		watch = 1'b1;
		for (i = 0; i < nw; i++) begin
			seed = lfsr(seed);
			w[i] = seed[15:0];
			push(w[i]);
			if (i == 0) begin
				@(posedge clk);
				#1;
				check("select low", fss_o, 1'b0);
				check("out enable", sout_oe, 1'b1);
			end
		end
		tx_valid = 1'b0;
		i = 0;
		while (busy !== 1'b0 && i < 5000) begin
			@(posedge clk);
			#1;
			i++;
		end
		repeat (4) @(posedge clk);
		#1;
		watch = 1'b0;
		check("edges", n_edges, nw * 2 * (fmt ? 9 + bits : bits));
		check("idle edges", idle_edges, 0);
		check("select rises", n_rise, (fmt || cpha) ? 1 : nw);
		check("lead", int'((t_first - t_fall) / 4.0), (!fmt && !cpha) ? 2 * d : d);
		check("tail", int'((t_rise - t_last) / 4.0), (fmt || !cpha) ? d : 2 * d);
		check("rx count", rxq.size(), nw);
		for (i = 0; i < nw; i++) begin
			check("rx word", rxq[i], (reply + 16'(sent + i)) & mask(size));
			check("tx word", capq[i], fmt ? {8'h00, w[i][7:0]} : w[i] & mask(size));
		end
		sent += nw;
		$display("test mode %0d words %0d done", mode, nw);
	endtask : run_case

	// ****
	// main sequence
	// ****
	initial begin
		int i;
		logic [7:0] mw;
		logic [7:0] sw;
		logic [7:0] got;
		repeat (20) @(posedge clk);
		#1;
		rstn = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		// disabled port must not start even with a word waiting
		enable = 1'b0;
		tx_valid = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		check("disabled busy", busy, 1'b0);
		check("disabled select", fss_o, 1'b1);
		tx_valid = 1'b0;
		enable = 1'b1;
		$display("test disabled done");
		for (int m = 0; m < 5; m++) begin
			for (int n = 1; n < 3; n++) run_case(m, n);
		end
		// slave: bench clocks at 48 ns, phase unrelated to the system clock
		master = 1'b0;
		fmt = 1'b0;
		cpol = 1'b0;
		cpha = 1'b0;
		size = 4'h7;
		seed = lfsr(seed);
		mw = seed[7:0];
		sw = seed[15:8];
		rxq.delete();
		repeat (4) @(posedge clk);
		#1;
		check("slave clock pad", sclk_oe, 1'b0);
		check("slave select pad", fss_oe, 1'b0);
		fork
			push({8'h00, sw});
			begin
				#20.3 m_fss = 1'b0;
				#48;
				for (i = 0; i < 8; i++) begin
					m_mosi = mw[7-i];
					#24 m_sclk = 1'b1;
					got[7-i] = sout;
					#24 m_sclk = 1'b0;
				end
				#48 m_fss = 1'b1;
				m_mosi = ~m_mosi;
			end
		join
		tx_valid = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		check("slave rx", rxq[0], {8'h00, mw});
		check("slave tx", got, sw);
		$display("test slave done");
		summarize();
	end

	// hang guard well beyond the longest expected run
	initial begin
		#400000;
		fails++;
		summarize();
	end
endmodule : tb
